// ==== iosad_chk.sv ====
`timescale 1ns/100ps
module iosad_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// core request and answer
	input wire logic req_valid,
	input wire iosad_pkg::iosad_req_t req,
	input wire logic ack,
	input wire logic refused,
	input wire logic [7:0] rdata,
	input wire logic skip,
	// extended region
	input wire logic ext_valid,
	input wire logic [7:0] ext_addr,
	// flags
	input wire logic [iosad_pkg::NFLAG-1:0][7:0] flag_evt,
	input wire logic [iosad_pkg::NFLAG-1:0][7:0] flags
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	// request classes, op codes as plain bits for range tests
	wire logic [2:0] opc = req.op;
	wire logic io_op = req_valid && opc < 3'h2;
	wire logic bit_op = req_valid && opc > 3'h1 && opc < 3'h6;
	wire logic dat_op = req_valid && opc > 3'h5;
	wire logic clr0 = req_valid && opc == 3'h1 && req.addr == 8'h15;

	// forwarded access, then the answer a cycle later
	sequence s_fwd;
		ext_valid && ext_addr == $past(req.addr);
	endsequence
	sequence s_done;
		ack && !refused;
	endsequence

	a_bit_refuse: assert property (bit_op && req.addr > 8'h1F |=> refused && ack)
		else $error("bit op above 0x1F was not refused");
	a_bit_accept: assert property (bit_op && req.addr <= 8'h1F |=> s_done)
		else $error("bit op in low map was not accepted");
	a_io_range: assert property (io_op && req.addr > 8'h3F |=> refused)
		else $error("direct access above 0x3F was not refused");
	a_io_accept: assert property (io_op && req.addr <= 8'h3F |=> s_done)
		else $error("direct access in range was not answered");
	a_data_low: assert property (dat_op && req.addr < 8'h20 |=> refused)
		else $error("data access below 0x20 was not refused");
	a_ext_fwd: assert property (dat_op && req.addr >= 8'h60 |=> s_fwd ##1 s_done)
		else $error("extended access not forwarded then answered");
	a_ext_source: assert property (ext_valid |-> $past(dat_op))
		else $error("extended strobe without a data access");
	a_refuse_quiet: assert property (refused |-> rdata == 8'h00 && !skip)
		else $error("refused access left data or skip");
	a_skip_source: assert property (skip |-> $past(req_valid && opc[2:1] == 2'b10))
		else $error("skip without a bit test");
	a_flag_clear: assert property (clr0 && req.wdata[1] && !flag_evt[0][1] |-> ##[1:2] !flags[0][1])
		else $error("writing one did not clear the flag");
endmodule : iosad_chk

bind iosad_io_decoder iosad_chk u_chk (.mclk(mclk), .rst_n(rst_n),
	.req_valid(req_valid), .req(req), .ack(ack), .refused(refused),
	.rdata(rdata), .skip(skip), .ext_valid(ext_valid),
	.ext_addr(ext_addr), .flag_evt(flag_evt), .flags(flags));

// ==== iosad_decode.sv ====
`timescale 1ns/100ps
module iosad_decode (
	// request from the core
	input wire iosad_pkg::iosad_req_t req,
	// decoded access
	output wire logic [5:0] io_addr,
	output wire logic io_hit,
	output wire logic ext_hit,
	output wire logic is_wr,
	output wire logic is_test,
	output wire logic refuse,
	output wire logic [7:0] wmask,
	output wire logic [7:0] wval
);
	wire logic bit_op;
	wire logic data_op;
	wire logic io_op;
	wire logic low_io;
	wire logic data_in_io;
	wire logic [7:0] bit_sel;
	wire logic [7:0] data_io;

	// classify the access kind
	assign bit_op = req.op inside {iosad_pkg::OP_BIT_SET, iosad_pkg::OP_BIT_CLR,
		iosad_pkg::OP_SKIP_ONE, iosad_pkg::OP_SKIP_ZERO};
	assign data_op = req.op inside {iosad_pkg::OP_DATA_LOAD,
		iosad_pkg::OP_DATA_STORE};
	assign io_op = !bit_op && !data_op;

	// data space sees the I/O map shifted up by the offset
	assign data_io = req.addr - iosad_pkg::DATA_IO_OFFSET;
	assign low_io = req.addr < iosad_pkg::DATA_IO_OFFSET;
	assign data_in_io = !low_io && (req.addr < iosad_pkg::EXT_FIRST);
	assign io_addr = data_op ? data_io[5:0] : req.addr[5:0];

	// direct I/O reaches 64 locations only; bit forms only the low 32
	assign io_hit = (io_op && req.addr < 8'(iosad_pkg::IO_LOCS))
		|| (bit_op && req.addr <= iosad_pkg::BIT_OP_LAST)
		|| (data_op && data_in_io);
	assign ext_hit = data_op && !low_io && !data_in_io;
	assign refuse = !io_hit && !ext_hit;

	// single-bit forms touch only the chosen bit
	assign bit_sel = 8'h01 << req.bit_idx;
	assign is_wr = io_hit && (req.op inside {iosad_pkg::OP_IO_OUT,
		iosad_pkg::OP_BIT_SET, iosad_pkg::OP_BIT_CLR,
		iosad_pkg::OP_DATA_STORE});
	assign is_test = io_hit && (req.op inside {iosad_pkg::OP_SKIP_ONE,
		iosad_pkg::OP_SKIP_ZERO});
	assign wmask = (req.op inside {iosad_pkg::OP_BIT_SET,
		iosad_pkg::OP_BIT_CLR}) ? bit_sel : 8'hFF;
	assign wval = (req.op == iosad_pkg::OP_BIT_SET) ? bit_sel :
		(req.op == iosad_pkg::OP_BIT_CLR) ? 8'h00 : req.wdata;
endmodule : iosad_decode

// ==== iosad_ext_model.sv ====
`timescale 1ns/100ps
module iosad_ext_model (
	// clock
	input wire logic mclk,
	// forwarded access
	input wire logic ext_valid,
	input wire logic ext_we,
	input wire logic [7:0] ext_addr,
	input wire logic [7:0] ext_wdata,
	// read answer, combinational
	output logic [7:0] ext_rdata
);
	logic [7:0] mem [256];
	logic [7:0] last_r = 8'h00;

	// stores land on the edge that samples the forwarded strobe
	always @(posedge mclk) begin
		if (ext_valid) begin
			if (ext_we)
				mem[ext_addr] <= ext_wdata;
			last_r <= mem[ext_addr];
		end
	end

	// idle bus shows a wrong value so a stale capture cannot pass
	assign ext_rdata = ext_valid ? mem[ext_addr] : ~last_r;
endmodule : iosad_ext_model

// ==== iosad_flag_reg.sv ====
`timescale 1ns/100ps
module iosad_flag_reg #(
	parameter logic [7:0] MASK = 8'hFF
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// hardware events and software clears
	input wire logic [7:0] set,
	input wire logic [7:0] clr,
	// flag state
	output wire logic [7:0] q
);
	logic [7:0] q_r;
	wire logic [7:0] q_nxt;

	// a set in the same cycle as a clear wins, so no event is lost
	assign q_nxt = ((q_r & ~clr) | set) & MASK;
	assign q = q_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q_r <= iosad_pkg::RST_VAL;
		end else begin
			q_r <= q_nxt;
		end
	end
endmodule : iosad_flag_reg

// ==== iosad_io_decoder.sv ====
`timescale 1ns/100ps
module iosad_io_decoder (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// access request from the core
	input wire logic req_valid,
	input wire iosad_pkg::iosad_req_t req,
	// answer to the core
	output logic ack,
	output logic refused,
	output logic [7:0] rdata,
	output logic skip,
	// extended region, served elsewhere
	output logic ext_valid,
	output logic ext_we,
	output logic [7:0] ext_addr,
	output logic [7:0] ext_wdata,
	input wire logic [7:0] ext_rdata,
	// port pins and comparator level, asynchronous
	input wire logic [7:0] pin_b,
	input wire logic [6:0] pin_c,
	input wire logic [7:0] pin_d,
	input wire logic cmp_level,
	// hardware events per flag register, one bit per flag
	input wire logic [iosad_pkg::NFLAG-1:0][7:0] flag_evt,
	// register contents for the peripherals
	output iosad_pkg::iosad_port_t ports,
	output logic [7:0] ext_irq_mask,
	output logic [7:0] nvm_ctl,
	output logic [7:0] global_tmr_ctl,
	output logic [7:0] timer0_ctl_a,
	output logic [7:0] timer0_ctl_b,
	output logic [7:0] timer0_count,
	output logic [7:0] timer0_cmp_a,
	output logic [7:0] timer0_cmp_b,
	output logic [7:0] spi_ctl,
	output logic [7:0] spi_status_ctl,
	output logic [7:0] spi_data,
	output logic [7:0] cmp_ctl,
	output logic [7:0] sleep_ctl,
	output logic [1:0] timer0_force,
	// flag state for the interrupt logic of the core
	output logic [iosad_pkg::NFLAG-1:0][7:0] flags
);
	localparam int NSYNC = 24;

	// synchroniser stages
	logic [NSYNC-1:0] pin_meta_r;
	logic [NSYNC-1:0] pin_sync_r;

	// decoded request
	wire logic [5:0] io_addr;
	wire logic io_hit;
	wire logic ext_hit;
	wire logic is_wr;
	wire logic is_test;
	wire logic refuse;
	wire logic [7:0] wmask;
	wire logic [7:0] wval;
	wire logic wr_io;
	wire logic [7:0] store_mask;
	wire logic [7:0] merged;

	// storage
	logic [7:0] plain_r [0:iosad_pkg::IO_LOCS-1];
	logic [1:0] force_r;

	// read path
	wire logic [7:0] pin_b_s;
	wire logic [7:0] pin_c_s;
	wire logic [7:0] pin_d_s;
	wire logic cmp_s;
	logic [7:0] flag_rd;
	logic [7:0] live_rd;
	wire logic [7:0] rd_byte;
	wire logic bit_pick;

	// answer stage
	logic ack_r;
	logic refused_r;
	logic [7:0] rdata_r;
	logic skip_r;
	logic ack_nxt;
	logic [7:0] rdata_nxt;
	wire logic skip_nxt;
	logic ext_valid_r;
	logic ext_we_r;
	logic [7:0] ext_addr_r;
	logic [7:0] ext_wdata_r;

	// pins come from outside the clock domain: two flops before use
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= {cmp_level, pin_d, pin_c, pin_b};
			pin_sync_r <= pin_meta_r;
		end
	end

	assign pin_b_s = pin_sync_r[7:0];
	assign pin_c_s = {1'b0, pin_sync_r[14:8]};
	assign pin_d_s = pin_sync_r[22:15];
	assign cmp_s = pin_sync_r[23];

	// address classification and write shaping
	iosad_decode u_decode (
		.req(req),
		.io_addr(io_addr),
		.io_hit(io_hit),
		.ext_hit(ext_hit),
		.is_wr(is_wr),
		.is_test(is_test),
		.refuse(refuse),
		.wmask(wmask),
		.wval(wval)
	);

	// a write lands only on a location the decoder accepted
	assign wr_io = req_valid && is_wr;
	assign store_mask = wmask & iosad_pkg::rw_mask(io_addr);
	// untouched bits keep their value, so one bit can change alone
	assign merged = (plain_r[io_addr] & ~store_mask)
		| (wval & store_mask);

	// plain storage; unmapped addresses have an empty mask and never change
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < iosad_pkg::IO_LOCS; i++) begin
				plain_r[i] <= iosad_pkg::RST_VAL;
			end
		end else if (wr_io) begin
			plain_r[io_addr] <= merged;
		end
	end

	// force-compare bits are write-only strobes, one cycle wide
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			force_r <= 2'h0;
		end else if (wr_io && io_addr == iosad_pkg::A_TIMER0_CTL_B) begin
			force_r <= 2'((wval & wmask & iosad_pkg::FORCE_CMP_BITS) >> 6);
		end else begin
			force_r <= 2'h0;
		end
	end

	// flag registers: hardware sets, software clears bit by bit
	for (genvar g = 0; g < iosad_pkg::NFLAG; g++) begin : g_flag
		localparam logic [5:0] FA = iosad_pkg::flag_addr(g);
		localparam logic [7:0] FM = iosad_pkg::flag_mask(g);
		localparam logic W0C = iosad_pkg::flag_w0c(g);
		wire logic hit;
		wire logic [7:0] clr;

		assign hit = wr_io && io_addr == FA;
		// writing one clears and zero keeps the flag; with W0C set, zero clears and one keeps
		assign clr = !hit ? 8'h00 :
			W0C ? (wmask & ~wval) : (wmask & wval);

		iosad_flag_reg #(
			.MASK(FM)
		) u_flag (
			.mclk(mclk),
			.rst_n(rst_n),
			.set(flag_evt[g]),
			.clr(clr),
			.q(flags[g])
		);
	end

	// fold the flag registers into the read byte
	always_comb begin
		flag_rd = 8'h00;
		for (int i = 0; i < iosad_pkg::NFLAG; i++) begin
			if (io_addr == iosad_pkg::flag_addr(i)) begin
				flag_rd = flag_rd | flags[i];
			end
		end
	end

	// live levels: synchronised pins and comparator output
	always_comb begin
		case (io_addr)
			iosad_pkg::A_PORT_B_PIN: live_rd = pin_b_s;
			iosad_pkg::A_PORT_C_PIN: live_rd = pin_c_s;
			iosad_pkg::A_PORT_D_PIN: live_rd = pin_d_s;
			iosad_pkg::A_CMP_CTL: live_rd = 8'(cmp_s) << iosad_pkg::CMP_OUT_BIT;
			default: live_rd = 8'h00;
		endcase
	end

	// reserved bits and addresses contribute nothing, so they read zero
	assign rd_byte = (plain_r[io_addr] & iosad_pkg::rw_mask(io_addr))
		| flag_rd | live_rd;

	// the test looks at one bit and nothing more
	assign bit_pick = rd_byte[req.bit_idx];
	assign skip_nxt = req_valid && is_test
		&& (bit_pick == (req.op == iosad_pkg::OP_SKIP_ONE));

	// answer: one cycle after an I/O access, one more for the ext region
	always_comb begin
		ack_nxt = (req_valid && !ext_hit) || ext_valid_r;
		if (ext_valid_r) begin
			rdata_nxt = ext_we_r ? 8'h00 : ext_rdata;
		end else if (req_valid && io_hit && !is_wr && !is_test) begin
			rdata_nxt = rd_byte;
		end else begin
			rdata_nxt = 8'h00;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
			refused_r <= 1'b0;
			rdata_r <= iosad_pkg::RST_VAL;
			skip_r <= 1'b0;
		end else begin
			ack_r <= ack_nxt;
			refused_r <= req_valid && refuse;
			rdata_r <= rdata_nxt;
			skip_r <= skip_nxt;
		end
	end

	// the ext region is handed on registered; it is never reached by I/O
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ext_valid_r <= 1'b0;
			ext_we_r <= 1'b0;
			ext_addr_r <= 8'h00;
			ext_wdata_r <= 8'h00;
		end else begin
			ext_valid_r <= req_valid && ext_hit;
			ext_we_r <= req.op == iosad_pkg::OP_DATA_STORE;
			ext_addr_r <= req.addr;
			ext_wdata_r <= req.wdata;
		end
	end

	assign ack = ack_r;
	assign refused = refused_r;
	assign rdata = rdata_r;
	assign skip = skip_r;
	assign ext_valid = ext_valid_r;
	assign ext_we = ext_we_r;
	assign ext_addr = ext_addr_r;
	assign ext_wdata = ext_wdata_r;
	assign timer0_force = force_r;

	// register contents straight from the storage flops
	assign ports.b_dir = plain_r[iosad_pkg::A_PORT_B_DIR];
	assign ports.b_out = plain_r[iosad_pkg::A_PORT_B_OUT];
	assign ports.c_dir = plain_r[iosad_pkg::A_PORT_C_DIR];
	assign ports.c_out = plain_r[iosad_pkg::A_PORT_C_OUT];
	assign ports.d_dir = plain_r[iosad_pkg::A_PORT_D_DIR];
	assign ports.d_out = plain_r[iosad_pkg::A_PORT_D_OUT];
	assign ext_irq_mask = plain_r[iosad_pkg::A_EXT_IRQ_MASK];
	assign nvm_ctl = plain_r[iosad_pkg::A_NVM_CTL];
	assign global_tmr_ctl = plain_r[iosad_pkg::A_GLOBAL_TMR_CTL];
	assign timer0_ctl_a = plain_r[iosad_pkg::A_TIMER0_CTL_A];
	assign timer0_ctl_b = plain_r[iosad_pkg::A_TIMER0_CTL_B];
	assign timer0_count = plain_r[iosad_pkg::A_TIMER0_COUNT];
	assign timer0_cmp_a = plain_r[iosad_pkg::A_TIMER0_CMP_A];
	assign timer0_cmp_b = plain_r[iosad_pkg::A_TIMER0_CMP_B];
	assign spi_ctl = plain_r[iosad_pkg::A_SPI_CTL];
	assign spi_status_ctl = plain_r[iosad_pkg::A_SPI_STATUS];
	assign spi_data = plain_r[iosad_pkg::A_SPI_DATA];
	assign cmp_ctl = plain_r[iosad_pkg::A_CMP_CTL];
	assign sleep_ctl = plain_r[iosad_pkg::A_SLEEP_CTL];

endmodule : iosad_io_decoder

// ==== iosad_io_decoder_tb.sv ====
`timescale 1ns/100ps
module iosad_io_decoder_tb;
	typedef struct packed {
		logic [2:0] op;
		logic [7:0] a;
		logic [2:0] b;
		logic [7:0] w;
		logic [7:0] rd;
		logic sk;
		logic rf;
	} iosad_row_t;

	// op, address, bit, write data, read data, skip, refused
	localparam iosad_row_t ROWS [23] = '{
		'{1, 'h1E, 0, 'hA5, 0, 0, 0}, '{0, 'h1E, 0, 0, 'hA5, 0, 0},
		'{6, 'h3E, 0, 0, 'hA5, 0, 0}, '{7, 'h4A, 0, 'h3C, 0, 0, 0},
		'{0, 'h2A, 0, 0, 'h3C, 0, 0}, '{2, 'h1E, 1, 'hFF, 0, 0, 0},
		'{3, 'h1E, 0, 0, 0, 0, 0}, '{0, 'h1E, 0, 0, 'hA6, 0, 0},
		'{4, 'h1E, 1, 0, 0, 1, 0}, '{5, 'h1E, 1, 0, 0, 0, 0},
		'{5, 'h1E, 0, 0, 0, 1, 0}, '{4, 'h1E, 0, 0, 0, 0, 0},
		'{2, 'h2A, 0, 0, 0, 0, 1}, '{4, 'h20, 5, 0, 0, 0, 1},
		'{0, 'h2A, 0, 0, 'h3C, 0, 0}, '{0, 'h40, 0, 0, 0, 0, 1},
		'{0, 'h32, 0, 0, 0, 0, 0}, '{0, 'h06, 0, 0, 'h7F, 0, 0},
		'{6, 'h1F, 0, 0, 0, 0, 1}, '{6, 'h23, 0, 0, 'h5A, 0, 0},
		'{7, 'h60, 0, 'h96, 0, 0, 0}, '{6, 'h60, 0, 0, 'h96, 0, 0},
		'{6, 'h5F, 0, 0, 0, 0, 0}
	};

	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	iosad_pkg::iosad_req_t req = '0;
	logic ack, refused, skip, ext_valid, ext_we;
	logic [7:0] rdata, ext_addr, ext_wdata, ext_rdata;
	logic [iosad_pkg::NFLAG-1:0][7:0] flag_evt = '0;
	logic [iosad_pkg::NFLAG-1:0][7:0] flags;
	iosad_pkg::iosad_port_t ports;
	logic [7:0] rd_s;
	logic sk_s, rf_s;
	logic [7:0] regs_o [13];
	logic [1:0] force_o, fo_s;

	// peripheral registers: address, byte written, level expected after
	localparam logic [7:0] OA [13] = '{8'h1D, 8'h1F, 8'h23, 8'h24, 8'h25,
		8'h26, 8'h27, 8'h28, 8'h2C, 8'h2D, 8'h2E, 8'h30, 8'h33};
	localparam logic [7:0] OW [13] = '{8'h02, 8'h2A, 8'h81, 8'hA3, 8'hC9,
		8'h5C, 8'h33, 8'hCC, 8'h96, 8'hC1, 8'h69, 8'hD9, 8'h05};
	localparam logic [7:0] OE [13] = '{8'h02, 8'h2A, 8'h81, 8'hA3, 8'h09,
		8'h5C, 8'h33, 8'hCC, 8'h96, 8'h01, 8'h69, 8'hC9, 8'h05};
	int errors = 0;
	int compares = 0;

	// 10 MHz system clock
	always #50 mclk = ~mclk;

	iosad_io_decoder u_dut (.mclk(mclk), .rst_n(rst_n),
		.req_valid(req_valid), .req(req), .ack(ack), .refused(refused),
		.rdata(rdata), .skip(skip), .ext_valid(ext_valid), .ext_we(ext_we),
		.ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
		.pin_b(8'h5A), .pin_c(7'h7F), .pin_d(8'hC3), .cmp_level(1'b0),
		.flag_evt(flag_evt), .ports(ports), .ext_irq_mask(regs_o[0]),
		.nvm_ctl(regs_o[1]), .global_tmr_ctl(regs_o[2]),
		.timer0_ctl_a(regs_o[3]), .timer0_ctl_b(regs_o[4]),
		.timer0_count(regs_o[5]), .timer0_cmp_a(regs_o[6]),
		.timer0_cmp_b(regs_o[7]), .spi_ctl(regs_o[8]),
		.spi_status_ctl(regs_o[9]), .spi_data(regs_o[10]),
		.cmp_ctl(regs_o[11]), .sleep_ctl(regs_o[12]),
		.timer0_force(force_o), .flags(flags));

	iosad_ext_model u_ext (.mclk(mclk), .ext_valid(ext_valid),
		.ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
		.ext_rdata(ext_rdata));

	task automatic chk(input logic [7:0] s, input logic [7:0] e,
		input string m);
		compares++;
		if (s !== e) begin
			errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, s, e);
		end
	endtask : chk

	// one pulse per access; entered and left 10 ns after an edge
	task automatic acc(input logic [2:0] op, input logic [7:0] a,
		input logic [2:0] b, input logic [7:0] w);
		int n;
		req = '{iosad_pkg::iosad_op_t'(op), a, b, w};
		req_valid = 1'b1;
		@(posedge mclk);
		#10 req_valid = 1'b0;
		for (n = 0; n < 4 && ack !== 1'b1; n++) begin
			@(posedge mclk);
			#1;
		end
		rd_s = rdata;
		sk_s = skip;
		rf_s = refused;
		fo_s = force_o;
		chk({7'h00, ack}, 8'h01, "no answer");
		// idle cycle so the strobe is never lowered and raised at once
		@(posedge mclk);
		#10;
	endtask : acc

	// one-cycle hardware event on a flag register
	task automatic evt(input int i, input logic [7:0] v);
		flag_evt[i] = v;
		@(posedge mclk);
		#10 flag_evt[i] = 8'h00;
	endtask : evt

	task automatic report_and_stop;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	// a hang ends the run as a failure
	initial begin
		#2000000;
		errors++;
		report_and_stop();
	end

	initial begin
		repeat (16) @(posedge mclk);
		#10 rst_n = 1'b1;
		chk(ports.b_out, 8'h00, "reset port b");
		chk(flags[0], 8'h00, "reset flags");
		$display("test reset done");
		foreach (ROWS[i]) begin
			acc(ROWS[i].op, ROWS[i].a, ROWS[i].b, ROWS[i].w);
			chk(rd_s, ROWS[i].rd, "read data");
			chk({7'h00, sk_s}, {7'h00, ROWS[i].sk}, "skip");
			chk({7'h00, rf_s}, {7'h00, ROWS[i].rf}, "refused");
		end
		$display("test table done");
		// flag registers: clear by one, keep on zero, bit ops
		evt(0, 8'h07);
		acc(0, 8'h15, 0, 0);
		chk(rd_s, 8'h07, "flags set");
		acc(1, 8'h15, 0, 8'h02);
		chk(flags[0], 8'h05, "clear by one");
		acc(1, 8'h15, 0, 8'h00);
		chk(flags[0], 8'h05, "zero keeps");
		acc(2, 8'h15, 2, 0);
		chk(flags[0], 8'h01, "bit set clears one");
		acc(3, 8'h15, 0, 0);
		chk(flags[0], 8'h01, "bit clear keeps");
		acc(4, 8'h15, 0, 0);
		chk({7'h00, sk_s}, 8'h01, "skip on flag");
		evt(7, 8'h0F);
		acc(1, 8'h34, 0, 8'h0E);
		chk(flags[7], 8'h0E, "reset cause clear");
		$display("test flags done");
		// writable bits reach the outputs and read back; strobes read zero
		foreach (OA[i]) begin
			acc(1, OA[i], 0, OW[i]);
			chk({6'h00, fo_s}, (i == 4) ? 8'h03 : 8'h00, "force");
			chk(regs_o[i], OE[i], "register out");
			acc(0, OA[i], 0, 0);
			chk(rd_s, OE[i], "register back");
		end
		acc(1, 8'h08, 0, 8'h41);
		chk(ports.c_out, 8'h41, "port c out");
		$display("test registers done");
		// second reset in mid-run clears the scratch register
		rst_n = 1'b0;
		@(posedge mclk);
		#10 rst_n = 1'b1;
		acc(0, 8'h1E, 0, 0);
		chk(rd_s, 8'h00, "scratch after reset");
		chk(flags[7], 8'h00, "flags after reset");
		chk(regs_o[12], 8'h00, "sleep after reset");
		$display("test second reset done");
		report_and_stop();
	end
endmodule : iosad_io_decoder_tb

// ==== iosad_pkg.sv ====
package iosad_pkg;

	// address space shape
	localparam int IO_LOCS = 64;
	localparam logic [7:0] BIT_OP_LAST = 8'h1F;
	localparam logic [7:0] DATA_IO_OFFSET = 8'h20;
	localparam logic [7:0] EXT_FIRST = 8'h60;
	localparam logic [7:0] RST_VAL = 8'h00;
	localparam int NFLAG = 8;

	// direct I/O addresses of the low map
	localparam logic [5:0] A_PORT_B_PIN = 6'h03;
	localparam logic [5:0] A_PORT_B_DIR = 6'h04;
	localparam logic [5:0] A_PORT_B_OUT = 6'h05;
	localparam logic [5:0] A_PORT_C_PIN = 6'h06;
	localparam logic [5:0] A_PORT_C_DIR = 6'h07;
	localparam logic [5:0] A_PORT_C_OUT = 6'h08;
	localparam logic [5:0] A_PORT_D_PIN = 6'h09;
	localparam logic [5:0] A_PORT_D_DIR = 6'h0A;
	localparam logic [5:0] A_PORT_D_OUT = 6'h0B;
	localparam logic [5:0] A_TIMER0_FLAGS = 6'h15;
	localparam logic [5:0] A_TIMER1_FLAGS = 6'h16;
	localparam logic [5:0] A_TIMER2_FLAGS = 6'h17;
	localparam logic [5:0] A_PIN_CHANGE_FLAGS = 6'h1B;
	localparam logic [5:0] A_EXT_IRQ_FLAGS = 6'h1C;
	localparam logic [5:0] A_EXT_IRQ_MASK = 6'h1D;
	localparam logic [5:0] A_SCRATCH0 = 6'h1E;
	localparam logic [5:0] A_NVM_CTL = 6'h1F;
	localparam logic [5:0] A_GLOBAL_TMR_CTL = 6'h23;
	localparam logic [5:0] A_TIMER0_CTL_A = 6'h24;
	localparam logic [5:0] A_TIMER0_CTL_B = 6'h25;
	localparam logic [5:0] A_TIMER0_COUNT = 6'h26;
	localparam logic [5:0] A_TIMER0_CMP_A = 6'h27;
	localparam logic [5:0] A_TIMER0_CMP_B = 6'h28;
	localparam logic [5:0] A_SCRATCH1 = 6'h2A;
	localparam logic [5:0] A_SCRATCH2 = 6'h2B;
	localparam logic [5:0] A_SPI_CTL = 6'h2C;
	localparam logic [5:0] A_SPI_STATUS = 6'h2D;
	localparam logic [5:0] A_SPI_DATA = 6'h2E;
	localparam logic [5:0] A_CMP_CTL = 6'h30;
	localparam logic [5:0] A_SLEEP_CTL = 6'h33;
	localparam logic [5:0] A_RESET_CAUSE = 6'h34;

	// field positions
	localparam int CMP_OUT_BIT = 5;
	localparam logic [7:0] FORCE_CMP_BITS = 8'hC0;

	// access kinds from the core
	typedef enum logic [2:0] {
		OP_IO_IN = 3'h0,
		OP_IO_OUT = 3'h1,
		OP_BIT_SET = 3'h2,
		OP_BIT_CLR = 3'h3,
		OP_SKIP_ONE = 3'h4,
		OP_SKIP_ZERO = 3'h5,
		OP_DATA_LOAD = 3'h6,
		OP_DATA_STORE = 3'h7
	} iosad_op_t;

	typedef struct packed {
		iosad_op_t op;
		logic [7:0] addr;
		logic [2:0] bit_idx;
		logic [7:0] wdata;
	} iosad_req_t;

	typedef struct packed {
		logic [7:0] b_dir;
		logic [7:0] b_out;
		logic [7:0] c_dir;
		logic [7:0] c_out;
		logic [7:0] d_dir;
		logic [7:0] d_out;
	} iosad_port_t;

	// bits software may store in the plain register array
	function automatic logic [7:0] rw_mask(input logic [5:0] a);
		case (a)
			A_PORT_B_DIR, A_PORT_B_OUT, A_PORT_D_DIR, A_PORT_D_OUT: rw_mask = 8'hFF;
			A_PORT_C_DIR, A_PORT_C_OUT: rw_mask = 8'h7F;
			A_EXT_IRQ_MASK: rw_mask = 8'h03;
			A_SCRATCH0, A_SCRATCH1, A_SCRATCH2: rw_mask = 8'hFF;
			A_NVM_CTL: rw_mask = 8'h3F;
			A_GLOBAL_TMR_CTL, A_TIMER0_COUNT: rw_mask = 8'hFF;
			A_TIMER0_CMP_A, A_TIMER0_CMP_B: rw_mask = 8'hFF;
			A_TIMER0_CTL_A: rw_mask = 8'hF3;
			A_TIMER0_CTL_B: rw_mask = 8'h0F;
			A_SPI_CTL, A_SPI_DATA: rw_mask = 8'hFF;
			A_SPI_STATUS: rw_mask = 8'h01;
			A_CMP_CTL: rw_mask = 8'hCF;
			A_SLEEP_CTL: rw_mask = 8'h0F;
			default: rw_mask = 8'h00;
		endcase
	endfunction : rw_mask

	// hardware-set flag registers: address, live bits, clear-on-zero kind
	function automatic logic [5:0] flag_addr(input int i);
		case (i)
			0: flag_addr = A_TIMER0_FLAGS;
			1: flag_addr = A_TIMER1_FLAGS;
			2: flag_addr = A_TIMER2_FLAGS;
			3: flag_addr = A_PIN_CHANGE_FLAGS;
			4: flag_addr = A_EXT_IRQ_FLAGS;
			5: flag_addr = A_SPI_STATUS;
			6: flag_addr = A_CMP_CTL;
			default: flag_addr = A_RESET_CAUSE;
		endcase
	endfunction : flag_addr

	function automatic logic [7:0] flag_mask(input int i);
		case (i)
			0, 2: flag_mask = 8'h07;
			1: flag_mask = 8'h27;
			3: flag_mask = 8'h07;
			4: flag_mask = 8'h03;
			5: flag_mask = 8'hC0;
			6: flag_mask = 8'h10;
			default: flag_mask = 8'h0F;
		endcase
	endfunction : flag_mask

	function automatic logic flag_w0c(input int i);
		flag_w0c = (i == NFLAG - 1);
	endfunction : flag_w0c

endpackage : iosad_pkg
